/* shared/asrc_defines.vh */
// register map, field positions, reset values and codes of the sequence/result control block
`ifndef ASRC_DEFINES_VH
`define ASRC_DEFINES_VH
// ----------------------------------------
// register index (byte offset is the index times four)
// ----------------------------------------
`define ASRC_IDX_TRIG_CTRL 4'h2
`define ASRC_IDX_SEQ_RES_CTRL 4'h3
`define ASRC_IDX_CHAN_START 4'h5
`define ASRC_IDX_STATUS 4'h6
`define ASRC_IDX_CCF 4'h7
`define ASRC_IDX_IRQ_STATUS 4'h8
`define ASRC_IDX_IRQ_MASK 4'h9
`define ASRC_IDX_COMPARE_EN 4'hA
// ----------------------------------------
// field positions
// ----------------------------------------
`define ASRC_BIT_JUSTIFY 7
`define ASRC_BIT_LEN_HI 6
`define ASRC_BIT_LEN_LO 3
`define ASRC_BIT_FIFO 2
`define ASRC_BIT_FRZ_HI 1
`define ASRC_BIT_FRZ_LO 0
`define ASRC_BIT_TRIG_LE 4
`define ASRC_BIT_TRIG_POL 3
`define ASRC_BIT_TRIG_EN 2
`define ASRC_BIT_CMP_IE 0
`define ASRC_BIT_SCAN 5
// ----------------------------------------
// reset values
// ----------------------------------------
`define ASRC_RST_SEQ_RES_CTRL 8'h20
`define ASRC_RST_TRIG_CTRL 8'h00
`define ASRC_RST_CHAN_START 8'h00
// ----------------------------------------
// debug halt codes
// ----------------------------------------
`define ASRC_FRZ_RUN 2'b00
`define ASRC_FRZ_FINISH 2'b10
`define ASRC_FRZ_NOW 2'b11
// ----------------------------------------
// interrupt status bits
// ----------------------------------------
`define ASRC_IRQ_SEQ_DONE 0
`define ASRC_IRQ_CONV_DONE 1
`define ASRC_IRQ_COMPARE 2
`define ASRC_IRQ_ABORT 3
// ----------------------------------------
// bus responses
// ----------------------------------------
`define ASRC_RESP_OKAY 2'b00
`define ASRC_RESP_SLVERR 2'b10
`endif

/* rtl/asrc_trig_detect.v */
// external trigger synchroniser and sensitivity decoder
`timescale 1ns/1ps
module asrc_trig_detect (
	input wire clk,
	input wire rst,
	input wire trig_pin,
	input wire trigger_level_not_edge,
	input wire trigger_polarity,
	output reg trig_event
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	reg lvl_q;
	wire agree;
	wire lvl_d;

	// three stages; a change counts only when stages two and three agree
	always @(posedge clk) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= trig_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign agree = (s2_q == s3_q);
	assign lvl_d = agree ? s3_q : lvl_q;

	// filtered level, then edge or level per the sensitivity bits
	always @(posedge clk) begin
		if (rst) begin
			lvl_q <= 1'b0;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	// 00 falling, 01 rising, 10 low level, 11 high level
	always @* begin
		case ({trigger_level_not_edge, trigger_polarity})
			2'b00: trig_event = lvl_q & ~lvl_d; // R1 R2
			2'b01: trig_event = ~lvl_q & lvl_d; // R1 R2
			2'b10: trig_event = ~lvl_q; // R1 R2
			default: trig_event = lvl_q; // R1 R2
		endcase
	end
endmodule

/* rtl/asrc_seq_ctrl.v */
// sequence engine: conversion counting, result index and complete flags
`timescale 1ns/1ps
`include "asrc_defines.vh"
module asrc_seq_ctrl #(
	parameter RES_ENTRIES = 8,
	parameter IDX_W = 3
) (
	input wire clk,
	input wire rst,
	input wire abort,
	input wire start,
	input wire trig_event,
	input wire trig_en,
	input wire scan,
	input wire fifo_mode,
	input wire [3:0] seq_len_code,
	input wire [1:0] debug_halt_select,
	input wire freeze,
	input wire conv_done,
	input wire [7:0] ccf_clear,
	output reg conv_start_q,
	output reg busy_q,
	output reg [IDX_W-1:0] result_index_q,
	output reg [7:0] ccf_q,
	output reg seq_done_q,
	output reg res_write_q,
	output reg [IDX_W-1:0] res_addr_q
);
	reg armed_q;
	reg [3:0] done_cnt_q;
	reg in_conv_q;
	wire [3:0] seq_len;
	wire halt_now;
	wire halt_new;
	wire last;
	wire [IDX_W-1:0] idx_inc;
	wire go;

	// 0000 and top-bit codes mean eight conversions
	assign seq_len = (seq_len_code[3] || seq_len_code == 4'h0) ? 4'h8 : seq_len_code; // R5
	// frozen immediately, or no new conversion after the current one
	assign halt_now = freeze && debug_halt_select == `ASRC_FRZ_NOW; // R14
	assign halt_new = freeze && (debug_halt_select == `ASRC_FRZ_NOW ||
		debug_halt_select == `ASRC_FRZ_FINISH); // R14
	assign last = (done_cnt_q + 4'h1) == seq_len;
	// wrap from the last entry back to zero
	assign idx_inc = (result_index_q == RES_ENTRIES - 1) ? {IDX_W{1'b0}} :
		result_index_q + 1'b1; // R9 R16
	assign go = start ? ~trig_en : (armed_q && trig_event && !busy_q);

	// sequence state; abort and start clear the index even in fifo mode
	always @(posedge clk) begin
		if (rst) begin
			armed_q <= 1'b0;
			busy_q <= 1'b0;
			in_conv_q <= 1'b0;
			done_cnt_q <= 4'h0;
			result_index_q <= {IDX_W{1'b0}};
			conv_start_q <= 1'b0;
			seq_done_q <= 1'b0;
			res_write_q <= 1'b0;
			res_addr_q <= {IDX_W{1'b0}};
		end else begin
			conv_start_q <= 1'b0;
			seq_done_q <= 1'b0;
			res_write_q <= 1'b0;
			if (abort || start) begin
				busy_q <= 1'b0; // R3 R15
				in_conv_q <= 1'b0;
				done_cnt_q <= 4'h0;
				result_index_q <= {IDX_W{1'b0}}; // R11
				armed_q <= start & trig_en; // R15
				if (go) begin
					busy_q <= 1'b1; // R15
				end
			end else if (go) begin
				busy_q <= 1'b1;
				done_cnt_q <= 4'h0;
				if (!fifo_mode) begin
					result_index_q <= {IDX_W{1'b0}}; // R7
				end
			end else if (busy_q && !in_conv_q && !halt_new) begin
				in_conv_q <= 1'b1;
				conv_start_q <= 1'b1;
			end else if (in_conv_q && conv_done && !halt_now) begin
				in_conv_q <= 1'b0;
				res_write_q <= 1'b1;
				res_addr_q <= result_index_q; // R7 R8
				result_index_q <= idx_inc; // R8
				done_cnt_q <= done_cnt_q + 4'h1;
				if (last) begin
					seq_done_q <= 1'b1;
					done_cnt_q <= 4'h0;
					busy_q <= scan & ~trig_en;
					if (!fifo_mode) begin
						result_index_q <= {IDX_W{1'b0}}; // R7
					end
				end
			end
		end
	end

	// one complete flag per written register; set beats clear
	always @(posedge clk) begin
		if (rst) begin
			ccf_q <= 8'h00;
		end else begin
			ccf_q <= (ccf_q & ~ccf_clear) |
				((in_conv_q && conv_done && !halt_now && !abort && !start) ?
				(8'h01 << result_index_q) : 8'h00); // R13
		end
	end
endmodule

/* rtl/asrc_top.v */
// axi4-lite register front end of the converter sequence/result control
//
// Functional notes
// R1: sensitivity codes 00 falling, 01 rising, 10 low level, 11 high level.
// R2: level/edge and polarity bits decode the external trigger when enabled.
// R3: any write to sequence/result control aborts the running sequence.
// R4: results unsigned; justify bit 7 zero left-aligns, one right-aligns.
// R5: length bits 6..3; 0000 or top bit set means 8, else 1..7.
// R6: reset leaves only the weight-four length bit set, four conversions.
// R7: non-fifo: n-th conversion goes to n-th result register.
// R8: fifo mode: index not reset at sequence edges; results go consecutively.
// R9: fifo scanning wraps the index after the last register.
// R10: current result index readable as counter in the status register.
// R11: abort or new start clears the counter, even in fifo mode.
// R12: fifo mode disables compare as if all compare enables were zero.
// R13: a complete flag sets for each result register written.
// R14: freeze bits 1..0: 00 run, 01 reserved, 10 finish then halt, 11 halt now.
// R15: write to channel/start aborts and starts; with trigger on it arms instead.
// R16: result file has eight entries; fifo index wraps seven to zero.
`timescale 1ns/1ps
`include "asrc_defines.vh"
module asrc_top #(
	parameter RES_ENTRIES = 8,
	parameter IDX_W = 3,
	parameter RES_W = 12
) (
	input wire CLK,
	input wire RST,
	input wire [31:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	output reg S_AXI_AWREADY,
	input wire [31:0] S_AXI_WDATA,
	input wire [3:0] S_AXI_WSTRB,
	input wire S_AXI_WVALID,
	output reg S_AXI_WREADY,
	output reg [1:0] S_AXI_BRESP,
	output reg S_AXI_BVALID,
	input wire S_AXI_BREADY,
	input wire [31:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	output reg S_AXI_ARREADY,
	output reg [31:0] S_AXI_RDATA,
	output reg [1:0] S_AXI_RRESP,
	output reg S_AXI_RVALID,
	input wire S_AXI_RREADY,
	input wire TRIG_PIN,
	input wire FREEZE,
	input wire CONV_DONE,
	input wire [RES_W-1:0] CONV_RAW,
	input wire CMP_MATCH,
	output reg CONV_START,
	output reg RES_WRITE,
	output reg [IDX_W-1:0] RES_ADDR,
	output reg [15:0] RES_DATA,
	output reg CMP_ACTIVE,
	output reg IRQ
);
	// ----------------------------------------
	// register state
	// ----------------------------------------
	reg [7:0] seq_res_ctrl_q;
	reg [7:0] trig_ctrl_q;
	reg [7:0] chan_start_q;
	reg [7:0] compare_en_q;
	reg [3:0] irq_status_q;
	reg [3:0] irq_mask_q;
	reg [31:0] aw_addr_q;
	reg aw_have_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg w_have_q;
	reg [RES_W-1:0] raw_q;
	reg [IDX_W-1:0] cmp_idx_q;
	reg cmp_pend_q;
	wire wr_fire;
	wire [3:0] wr_idx;
	wire wr_ok;
	wire wr_seq;
	wire wr_start;
	wire [3:0] rd_idx;
	wire trig_event;
	wire conv_start;
	wire busy;
	wire [IDX_W-1:0] result_index;
	wire [7:0] ccf;
	wire seq_done;
	wire res_write;
	wire [IDX_W-1:0] res_addr;
	wire fifo_mode;
	wire cmp_on;
	wire [7:0] ccf_clear;
	wire [3:0] irq_set;
	reg [31:0] rd_data;
	reg rd_ok;

	assign fifo_mode = seq_res_ctrl_q[`ASRC_BIT_FIFO];
	assign wr_fire = aw_have_q && w_have_q && !S_AXI_BVALID;
	assign wr_idx = aw_addr_q[5:2];
	assign wr_ok = aw_addr_q[31:6] == 26'h0 && aw_addr_q[1:0] == 2'b00 &&
		(wr_idx == `ASRC_IDX_TRIG_CTRL || wr_idx == `ASRC_IDX_SEQ_RES_CTRL ||
		wr_idx == `ASRC_IDX_CHAN_START || wr_idx == `ASRC_IDX_CCF ||
		wr_idx == `ASRC_IDX_IRQ_STATUS || wr_idx == `ASRC_IDX_IRQ_MASK ||
		wr_idx == `ASRC_IDX_COMPARE_EN);
	// byte-lane-0 writes only: no register is wider than eight bits
	assign wr_seq = wr_fire && wr_ok && wr_idx == `ASRC_IDX_SEQ_RES_CTRL && w_strb_q[0];
	assign wr_start = wr_fire && wr_ok && wr_idx == `ASRC_IDX_CHAN_START && w_strb_q[0];
	assign ccf_clear = (wr_fire && wr_ok && wr_idx == `ASRC_IDX_CCF && w_strb_q[0]) ?
		w_data_q[7:0] : 8'h00;
	// compare is forced off in fifo mode
	assign cmp_on = !fifo_mode && trig_ctrl_q[`ASRC_BIT_CMP_IE]; // R12

	// ----------------------------------------
	// axi write channel: address and data in either order
	// ----------------------------------------
	always @(posedge CLK) begin
		if (RST) begin
			S_AXI_AWREADY <= 1'b1;
			S_AXI_WREADY <= 1'b1;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `ASRC_RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_addr_q <= S_AXI_AWADDR;
				aw_have_q <= 1'b1;
				S_AXI_AWREADY <= 1'b0;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_data_q <= S_AXI_WDATA;
				w_strb_q <= S_AXI_WSTRB;
				w_have_q <= 1'b1;
				S_AXI_WREADY <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_ok ? `ASRC_RESP_OKAY : `ASRC_RESP_SLVERR;
			end
			if (S_AXI_BVALID && S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
				S_AXI_AWREADY <= 1'b1;
				S_AXI_WREADY <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always @(posedge CLK) begin
		if (RST) begin
			seq_res_ctrl_q <= `ASRC_RST_SEQ_RES_CTRL; // R6
			trig_ctrl_q <= `ASRC_RST_TRIG_CTRL;
			chan_start_q <= `ASRC_RST_CHAN_START;
			compare_en_q <= 8'h00;
			irq_mask_q <= 4'h0;
		end else if (wr_fire && wr_ok && w_strb_q[0]) begin
			case (wr_idx)
				`ASRC_IDX_SEQ_RES_CTRL: seq_res_ctrl_q <= w_data_q[7:0];
				`ASRC_IDX_TRIG_CTRL: trig_ctrl_q <= w_data_q[7:0];
				`ASRC_IDX_CHAN_START: chan_start_q <= w_data_q[7:0];
				`ASRC_IDX_COMPARE_EN: compare_en_q <= w_data_q[7:0];
				`ASRC_IDX_IRQ_MASK: irq_mask_q <= w_data_q[3:0];
				default: irq_mask_q <= irq_mask_q;
			endcase
		end
	end

	// ----------------------------------------
	// interrupt status: sticky, write one to clear, set wins
	// ----------------------------------------
	assign irq_set = {wr_seq | (wr_start & busy),
		cmp_pend_q & CMP_MATCH,
		res_write, seq_done};
	always @(posedge CLK) begin
		if (RST) begin
			irq_status_q <= 4'h0;
			IRQ <= 1'b0;
		end else begin
			if (wr_fire && wr_ok && wr_idx == `ASRC_IDX_IRQ_STATUS && w_strb_q[0]) begin
				irq_status_q <= (irq_status_q & ~w_data_q[3:0]) | irq_set;
			end else begin
				irq_status_q <= irq_status_q | irq_set;
			end
			IRQ <= |((irq_status_q | irq_set) & irq_mask_q);
		end
	end

	// ----------------------------------------
	// result formatting and compare pairing
	// ----------------------------------------
	// unsigned data; left-aligned unless justify bit set
	always @(posedge CLK) begin
		if (RST) begin
			raw_q <= {RES_W{1'b0}};
			RES_WRITE <= 1'b0;
			RES_ADDR <= {IDX_W{1'b0}};
			RES_DATA <= 16'h0000;
			CONV_START <= 1'b0;
			CMP_ACTIVE <= 1'b0;
			cmp_pend_q <= 1'b0;
			cmp_idx_q <= {IDX_W{1'b0}};
		end else begin
			if (CONV_DONE) begin
				raw_q <= CONV_RAW;
			end
			RES_WRITE <= res_write;
			RES_ADDR <= res_addr;
			CONV_START <= conv_start;
			if (seq_res_ctrl_q[`ASRC_BIT_JUSTIFY]) begin
				RES_DATA <= {{(16-RES_W){1'b0}}, raw_q}; // R4
			end else begin
				RES_DATA <= {raw_q, {(16-RES_W){1'b0}}}; // R4
			end
			cmp_pend_q <= res_write && cmp_on && compare_en_q[res_addr]; // R12
			cmp_idx_q <= res_addr;
			CMP_ACTIVE <= res_write && cmp_on && compare_en_q[res_addr]; // R12
		end
	end

	// ----------------------------------------
	// axi read channel
	// ----------------------------------------
	assign rd_idx = S_AXI_ARADDR[5:2];
	always @* begin
		rd_data = 32'h0000_0000;
		rd_ok = S_AXI_ARADDR[31:6] == 26'h0 && S_AXI_ARADDR[1:0] == 2'b00;
		case (rd_idx)
			`ASRC_IDX_TRIG_CTRL: rd_data[7:0] = trig_ctrl_q;
			`ASRC_IDX_SEQ_RES_CTRL: rd_data[7:0] = seq_res_ctrl_q;
			`ASRC_IDX_CHAN_START: rd_data[7:0] = chan_start_q;
			`ASRC_IDX_STATUS: rd_data[7:0] = {busy, 4'h0, result_index}; // R10
			`ASRC_IDX_CCF: rd_data[7:0] = ccf;
			`ASRC_IDX_IRQ_STATUS: rd_data[3:0] = irq_status_q;
			`ASRC_IDX_IRQ_MASK: rd_data[3:0] = irq_mask_q;
			`ASRC_IDX_COMPARE_EN: rd_data[7:0] = compare_en_q;
			default: rd_ok = 1'b0;
		endcase
	end
	always @(posedge CLK) begin
		if (RST) begin
			S_AXI_ARREADY <= 1'b1;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0000_0000;
			S_AXI_RRESP <= `ASRC_RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA <= rd_ok ? rd_data : 32'h0000_0000;
			S_AXI_RRESP <= rd_ok ? `ASRC_RESP_OKAY : `ASRC_RESP_SLVERR;
		end else if (S_AXI_RVALID && S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_ARREADY <= 1'b1;
		end
	end

	// ----------------------------------------
	// sub-blocks
	// ----------------------------------------
	asrc_trig_detect u_trig (
		.clk(CLK),
		.rst(RST),
		.trig_pin(TRIG_PIN),
		.trigger_level_not_edge(trig_ctrl_q[`ASRC_BIT_TRIG_LE]),
		.trigger_polarity(trig_ctrl_q[`ASRC_BIT_TRIG_POL]),
		.trig_event(trig_event)
	);

	asrc_seq_ctrl #(
		.RES_ENTRIES(RES_ENTRIES),
		.IDX_W(IDX_W)
	) u_seq (
		.clk(CLK),
		.rst(RST),
		.abort(wr_seq), // R3
		.start(wr_start), // R15
		.trig_event(trig_event),
		.trig_en(trig_ctrl_q[`ASRC_BIT_TRIG_EN]),
		.scan(chan_start_q[`ASRC_BIT_SCAN]),
		.fifo_mode(fifo_mode),
		.seq_len_code(seq_res_ctrl_q[`ASRC_BIT_LEN_HI:`ASRC_BIT_LEN_LO]),
		.debug_halt_select(seq_res_ctrl_q[`ASRC_BIT_FRZ_HI:`ASRC_BIT_FRZ_LO]),
		.freeze(FREEZE),
		.conv_done(CONV_DONE),
		.ccf_clear(ccf_clear),
		.conv_start_q(conv_start),
		.busy_q(busy),
		.result_index_q(result_index),
		.ccf_q(ccf),
		.seq_done_q(seq_done),
		.res_write_q(res_write),
		.res_addr_q(res_addr)
	);
endmodule

/* bench/asrc_checker_assertions.sv */
// port-level assertions of the sequence/result control block
`timescale 1ns/1ps
module asrc_checker (
	input wire CLK,
	input wire RST,
	input wire [31:0] S_AXI_AWADDR,
	input wire S_AXI_AWVALID,
	input wire S_AXI_AWREADY,
	input wire S_AXI_WVALID,
	input wire S_AXI_WREADY,
	input wire S_AXI_BVALID,
	input wire [31:0] S_AXI_ARADDR,
	input wire S_AXI_ARVALID,
	input wire S_AXI_ARREADY,
	input wire [31:0] S_AXI_RDATA,
	input wire [1:0] S_AXI_RRESP,
	input wire S_AXI_RVALID,
	input wire FREEZE,
	input wire CONV_DONE,
	input wire CONV_START,
	input wire RES_WRITE
);
	// ----------------------------------------
	// shared clocking and step sequences
	// ----------------------------------------
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_ar_taken;
		S_AXI_ARVALID && S_AXI_ARREADY;
	endsequence
	sequence s_res_follow;
		##2 RES_WRITE;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_START_PULSE: assert property (CONV_START |=> !CONV_START)
		else $error("start pulse wider than one cycle");
	AST_RES_FOLLOWS: assert property (CONV_DONE && !FREEZE |-> s_res_follow)
		else $error("no result write two cycles after done");
	AST_RES_PULSE: assert property (RES_WRITE |=> !RES_WRITE)
		else $error("result write wider than one cycle");
	AST_RD_ANSWER: assert property (s_ar_taken |=> S_AXI_RVALID)
		else $error("read answer late");
	AST_RD_UNMAPPED: assert property (s_ar_taken ##0 (S_AXI_ARADDR[7:0] == 8'h04)
		|=> S_AXI_RRESP == 2'b10 && S_AXI_RDATA == 32'h0000_0000)
		else $error("unmapped read not refused");
	AST_RDATA_BYTE: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	// both halves held one edge, response launched on the next
	AST_WR_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
		&& S_AXI_WREADY |-> ##2 S_AXI_BVALID)
		else $error("write answer late");
	// an abort must not be followed by a fresh conversion; a request
	// launched just before the abort edge may still show on the pin
	AST_ABORT_QUIET: assert property (S_AXI_AWVALID && S_AXI_AWREADY
		&& S_AXI_WVALID && S_AXI_WREADY
		&& S_AXI_AWADDR[7:0] == 8'h0C |-> ##3 !CONV_START [*4])
		else $error("conversion started after abort");
endmodule
bind asrc_top asrc_checker u_chk (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(S_AXI_AWADDR),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
	.S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
	.S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
	.S_AXI_RVALID(S_AXI_RVALID), .FREEZE(FREEZE), .CONV_DONE(CONV_DONE),
	.CONV_START(CONV_START), .RES_WRITE(RES_WRITE));

/* bench/asrc_top_tb.sv */
// self-checking bench of the sequence/result control block
`timescale 1ns/1ps
module asrc_top_tb;
	logic CLK = 0;
	logic RST = 1;
	logic [31:0] aw = 0, wd = 0, ar = 0, seed = 32'hd294;
	logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0, trig = 0, frz = 0, cdone = 0, fifo_on = 0;
	logic cmp_exp = 0;
	logic [11:0] raw = 0;
	wire awr, wrdy, bv, arr, rv, cst, rw, cact, irq;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	wire [2:0] raddr;
	wire [15:0] rdat;
	int fail_count = 0;
	int checks = 0;
	asrc_top u_dut (.CLK(CLK), .RST(RST), .S_AXI_AWADDR(aw), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(br),
		.S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr), .TRIG_PIN(trig),
		.FREEZE(frz), .CONV_DONE(cdone), .CONV_RAW(raw), .CMP_MATCH(1'b1), .CONV_START(cst),
		.RES_WRITE(rw), .RES_ADDR(raddr), .RES_DATA(rdat), .CMP_ACTIVE(cact), .IRQ(irq));
	// ----------------------------------------
	// clock, helpers, bus tasks
	// ----------------------------------------
	always #10 CLK = ~CLK;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int seq_len(input logic [3:0] c);
		return (c == 4'h0 || c[3]) ? 8 : int'(c);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (fail_count == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// address and data offered together, each released when taken
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		@(posedge CLK);
		aw <= {idx, 2'b00};
		wd <= {24'h00_0000, d};
		awv <= 1;
		wv <= 1;
		br <= 1;
		do begin
			@(posedge CLK);
			if (awr) awv <= 0;
			if (wrdy) wv <= 0;
		end while (!bv);
		br <= 0;
		chk(bresp, 2'b00);
	endtask
	task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge CLK);
		ar <= {idx, 2'b00};
		arv <= 1;
		rr <= 1;
		do begin
			@(posedge CLK);
			if (arr) arv <= 0;
		end while (!rv);
		d = rdata;
		r = rresp;
		rr <= 0;
	endtask
	// answer one conversion request and check where the result lands
	task automatic conv(input logic [2:0] addr, input logic j);
		int n;
		logic [31:0] t;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (!cst && n < 60);
		t = xs();
		repeat (t[1:0]) @(posedge CLK);
		raw <= t[15:4];
		cdone <= 1;
		@(posedge CLK);
		cdone <= 0;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (!rw && n < 8);
		chk(rw, 1);
		chk(raddr, addr);
		chk(rdat, j ? {4'h0, t[15:4]} : {t[15:4], 4'h0});
		chk(cact, cmp_exp);
	endtask
	task automatic quiet(input int cyc);
		int n;
		n = 0;
		repeat (cyc) begin
			@(posedge CLK);
			n += cst;
		end
		chk(n, 0);
	endtask
	// one run: set control, start, serve total conversions, then abort
	task automatic run(input logic [3:0] len, input logic fifo, input logic scan, input int total);
		logic [31:0] t, d, m;
		logic [1:0] r;
		logic [2:0] a;
		t = xs();
		wr(3, {t[0], len, fifo, 2'b00});
		fifo_on = fifo;
		cmp_exp = !fifo;
		wr(7, 8'hff);
		wr(5, {2'b00, scan, 5'h00});
		m = 0;
		for (int i = 0; i < total; i++) begin
			a = 3'(fifo ? i % 8 : i % seq_len(len));
			conv(a, t[0]);
			m |= 32'h1 << a;
		end
		rd(7, d, r);
		chk(d, m);
		rd(6, d, r);
		chk(d & 32'h87, {scan, 4'h0, 3'(fifo ? total % 8 : total % seq_len(len))});
		wr(3, {t[0], len, fifo, 2'b00});
		rd(6, d, r);
		chk(d & 32'h87, 0);
		fifo_on = 0;
		cmp_exp = 0;
	endtask
	// compare must stay silent whenever fifo placement is on
	always @(negedge CLK) if (fifo_on) chk(cact, 0);
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		#1ms;
		fail_count++;
		final_report;
	end
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int n;
		repeat (3) @(posedge CLK);
		RST <= 0;
		rd(3, d, r);
		chk(d, 32'h20);
		rd(1, d, r);
		chk(r, 2'b10);
		wr(9, 8'h00);
		wr(2, 8'h01);
		wr(10, 8'hff);
		for (int c = 0; c < 16; c++) run(c[3:0], 0, 0, seq_len(c[3:0]));
		chk(irq, 0);
		rd(8, d, r);
		chk(d, 32'hf);
		wr(9, 8'h02);
		@(negedge CLK);
		chk(irq, 1);
		wr(8, 8'h0f);
		repeat (2) @(negedge CLK);
		chk(irq, 0);
		run(4'h2, 0, 1, 5);
		wr(8, 8'h0f);
		run(4'h3, 1, 1, 9);
		rd(8, d, r);
		chk(d[2:1], 2'b01);
		for (int k = 0; k < 4; k++) begin
			trig <= ~k[0];
			wr(2, {3'b000, k[1:0], 3'b100});
			wr(3, 8'h08);
			wr(5, 8'h00);
			quiet(12);
			trig <= k[0];
			conv(0, 0);
			trig <= ~k[0];
			repeat (10) @(posedge CLK);
			wr(3, 8'h08);
		end
		wr(2, 8'h00);
		frz <= 1;
		wr(3, 8'h0a);
		wr(5, 8'h00);
		quiet(12);
		frz <= 0;
		conv(0, 0);
		frz <= 1;
		wr(3, 8'h08);
		wr(5, 8'h00);
		conv(0, 0);
		frz <= 0;
		// halt at once: a done that lands while frozen is dropped
		wr(3, 8'h0b);
		wr(5, 8'h00);
		frz <= 1;
		cdone <= 1;
		@(posedge CLK);
		cdone <= 0;
		n = 0;
		repeat (8) begin
			@(posedge CLK);
			n += rw;
		end
		chk(n, 0);
		frz <= 0;
		cdone <= 1;
		@(posedge CLK);
		cdone <= 0;
		repeat (2) @(posedge CLK);
		chk(rw, 1);
		final_report;
	end
endmodule
